// File: core/motor_cfg_pkg.sv
// Notes on behaviour
// - nominal supply code in word 20 [7:0]; volts = code / 255 * 20
// - nominal rotation rate in word 8 [10:0]; 0.530 Hz per count
// - launch current = nominal current * 1/8 * (word 10 [15:11] + 1)
// - position-probe current limit word 18 [13:8], 0.04 A per count
// - nudge amplitude percent = word 21 [7:5] * 3.2 + 2.4
// - word 13 bit 14 set delays motor startup by 100 ms
// - word 11 bit 15 one opens inductance tuning window, zero is normal
// - overcurrent fault clears on restart (16[3]=0) or after 5 s (16[3]=1)
// - word 17 bit 9 selects register speed 17 [8:0] over duty pin
// - each word is 16 bits, store of 24 words
// - words are numbered registers reached over the two-wire serial bus
package motor_cfg_pkg;
   // ----------------------------------------------------------------
   // storage shape
   // ----------------------------------------------------------------
   localparam int unsigned  WORD_W     = 16;
   localparam int unsigned  WORD_COUNT = 24;
   localparam logic [15:0]  WORD_RESET = 16'h0000;
   // ----------------------------------------------------------------
   // register numbers
   // ----------------------------------------------------------------
   localparam logic [7:0] RATED_SPEED_AND_FLAGS_WORD = 8'h08;
   localparam logic [7:0] ACCEL_AND_RESISTANCE_WORD  = 8'h09;
   localparam logic [7:0] CURRENT_SETTING_WORD       = 8'h0a;
   localparam logic [7:0] DRIVE_AND_STARTUP_WORD     = 8'h0b;
   localparam logic [7:0] OBSERVER_GAIN_P_WORD       = 8'h0c;
   localparam logic [7:0] OBSERVER_GAIN_I_WORD       = 8'h0d;
   localparam logic [7:0] SOFT_RAMP_WORD             = 8'h0f;
   localparam logic [7:0] PROTECTION_AND_BUFFER_WORD = 8'h10;
   localparam logic [7:0] SPEED_COMMAND_WORD         = 8'h11;
   localparam logic [7:0] PROBE_THRESHOLD_WORD       = 8'h12;
   localparam logic [7:0] NOMINAL_SUPPLY_WORD        = 8'h14;
   localparam logic [7:0] NUDGE_AND_DUTY_WORD        = 8'h15;
   localparam logic [7:0] LOOP_TIME_CONSTANT_WORD    = 8'h16;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned SUPPLY_LSB = 0;   // 8 bits
   localparam int unsigned SPEED_LSB  = 0;   // 11 bits
   localparam int unsigned CURR_LSB   = 0;   // 11 bits
   localparam int unsigned LAUNCH_LSB = 11;  // 5 bits
   localparam int unsigned PROBE_LSB  = 8;   // 6 bits
   localparam int unsigned NUDGE_LSB  = 5;   // 3 bits
   localparam int unsigned DELAY_BIT  = 14;
   localparam int unsigned TUNE_BIT   = 15;
   localparam int unsigned RECOV_BIT  = 3;
   localparam int unsigned SEL_BIT    = 9;
   localparam int unsigned DEMAND_LSB = 0;   // 9 bits
   // nudge demand in tenths of percent: value*32 + 24
   localparam logic [7:0] NUDGE_STEP  = 8'h20;
   localparam logic [7:0] NUDGE_BASE  = 8'h18;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned DELAY_MS       = 100;
   localparam int unsigned DELAY_CYCLES   = CLK_HZ / 1000 * DELAY_MS;
   localparam int unsigned RECOVER_S      = 5;
   localparam int unsigned RECOVER_CYCLES = CLK_HZ * RECOVER_S;
   // bus address, arbitrary value
   localparam logic [6:0]  BUS_ADDR_DEFAULT = 7'h2a;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  supply_code;
      logic [10:0] rated_speed;
      logic [10:0] rated_current;
      logic [13:0] launch_current;
      logic [5:0]  probe_limit;
      logic [7:0]  nudge_tenths;
      logic        tuning_window;
      logic        auto_recover;
   } motor_cfg_t;
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_ACK_A = 9'h004,
      ST_REG   = 9'h008,
      ST_ACK_R = 9'h010,
      ST_WDATA = 9'h020,
      ST_ACK_W = 9'h040,
      ST_RDATA = 9'h080,
      ST_MACK  = 9'h100
   } bus_state_t;
endpackage

// File: core/motor_param_config_bank.sv
`timescale 1ns/1ps
module motor_param_config_bank
   import motor_cfg_pkg::*;
#(
   parameter int unsigned DELAY_CNT   = DELAY_CYCLES,
   parameter int unsigned RECOVER_CNT = RECOVER_CYCLES,
   parameter logic [6:0]  BUS_ADDR    = BUS_ADDR_DEFAULT
)(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // two-wire serial bus
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // motor control side
   input  wire logic       start_req,
   input  wire logic       overcurrent_event,
   input  wire logic [8:0] duty_pin_cmd,
   output logic [8:0]      speed_cmd,
   output logic            motor_run,
   output logic            fault_active,
   output motor_cfg_t      cfg
);
   // ----------------------------------------------------------------
   // storage and bus state
   // ----------------------------------------------------------------
   logic [15:0] words_ff [WORD_COUNT];
   logic [2:0]  scl_ff;
   logic [2:0]  sda_ff;
   bus_state_t  state_ff;
   logic [3:0]  cnt_ff;
   logic [7:0]  shift_ff;
   logic [7:0]  tx_ff;
   logic [7:0]  ptr_ff;
   logic [7:0]  hold_ff;
   logic        hi_ff;
   logic        rw_ff;
   logic        nack_ff;
   logic        oe_ff;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        wr_en;
   logic [15:0] wr_word;
   logic [15:0] rd_word;

   function automatic logic in_range(input logic [7:0] idx);
      in_range = (idx < 8'(WORD_COUNT));
   endfunction

   function automatic logic [15:0] word_at(input logic [7:0] idx);
      if (in_range(idx)) begin
         word_at = words_ff[idx[4:0]];
      end else begin
         word_at = 16'h0000;
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers; stage 0 feeds only stage 1
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         scl_ff <= 3'h7;
         sda_ff <= 3'h7;
      end else begin
         scl_ff <= {scl_ff[1:0], scl_in};
         sda_ff <= {sda_ff[1:0], sda_in};
      end
   end

   // edges and bus conditions from the settled stages only
   assign scl_rise  = scl_ff[1] & ~scl_ff[2];
   assign scl_fall  = ~scl_ff[1] & scl_ff[2];
   assign bus_start = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
   assign bus_stop  = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];
   // a word is committed only when its low byte completes
   assign wr_en     = (state_ff == ST_WDATA) && scl_fall && (cnt_ff == 4'h8) && !hi_ff;
   assign wr_word   = {hold_ff, shift_ff};

   // a process, not an assign: it also wakes on a store write, not only on a pointer move
   always_comb begin
      rd_word = word_at(ptr_ff);
   end

   // ----------------------------------------------------------------
   // serial slave: address, register number, 16-bit words high first
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 4'h0;
         shift_ff <= 8'h00;
         tx_ff    <= 8'h00;
         ptr_ff   <= 8'h00;
         hold_ff  <= 8'h00;
         hi_ff    <= 1'b1;
         rw_ff    <= 1'b0;
         nack_ff  <= 1'b0;
         oe_ff    <= 1'b0;
      end else if (bus_start) begin
         state_ff <= ST_ADDR;   // repeated start keeps the pointer
         cnt_ff   <= 4'h0;
         hi_ff    <= 1'b1;
         oe_ff    <= 1'b0;
      end else if (bus_stop) begin
         state_ff <= ST_IDLE;
         oe_ff    <= 1'b0;
      end else if (scl_rise) begin
         case (state_ff)
            ST_ADDR, ST_REG, ST_WDATA: begin
               shift_ff <= {shift_ff[6:0], sda_ff[1]};
               cnt_ff   <= cnt_ff + 4'h1;
            end
            ST_RDATA: cnt_ff <= cnt_ff + 4'h1;
            ST_MACK:  nack_ff <= sda_ff[1];
            default: ;
         endcase
      end else if (scl_fall) begin
         case (state_ff)
            ST_ADDR: begin
               if (cnt_ff == 4'h8) begin
                  cnt_ff <= 4'h0;
                  if (shift_ff[7:1] == BUS_ADDR) begin
                     rw_ff    <= shift_ff[0];
                     oe_ff    <= 1'b1;
                     state_ff <= ST_ACK_A;
                  end else begin
                     state_ff <= ST_IDLE;   // other targets are ignored
                  end
               end
            end
            ST_ACK_A: begin
               cnt_ff <= 4'h0;
               if (rw_ff) begin
                  oe_ff    <= ~rd_word[15];
                  tx_ff    <= {rd_word[14:8], 1'b0};
                  hi_ff    <= 1'b0;
                  state_ff <= ST_RDATA;
               end else begin
                  oe_ff    <= 1'b0;
                  state_ff <= ST_REG;
               end
            end
            ST_REG: begin
               if (cnt_ff == 4'h8) begin
                  ptr_ff   <= shift_ff;
                  cnt_ff   <= 4'h0;
                  oe_ff    <= 1'b1;
                  state_ff <= ST_ACK_R;
               end
            end
            ST_ACK_R, ST_ACK_W: begin
               oe_ff    <= 1'b0;
               state_ff <= ST_WDATA;
            end
            ST_WDATA: begin
               if (cnt_ff == 4'h8) begin
                  cnt_ff   <= 4'h0;
                  oe_ff    <= 1'b1;
                  state_ff <= ST_ACK_W;
                  hi_ff    <= ~hi_ff;
                  if (hi_ff) begin
                     hold_ff <= shift_ff;
                  end else begin
                     ptr_ff  <= ptr_ff + 8'h01;   // auto-increment per word
                  end
               end
            end
            ST_RDATA: begin
               if (cnt_ff == 4'h8) begin
                  oe_ff    <= 1'b0;
                  state_ff <= ST_MACK;
               end else begin
                  oe_ff <= ~tx_ff[7];
                  tx_ff <= {tx_ff[6:0], 1'b0};
               end
            end
            ST_MACK: begin
               cnt_ff <= 4'h0;
               if (nack_ff) begin
                  state_ff <= ST_IDLE;   // master ends the read
               end else if (!hi_ff) begin
                  oe_ff    <= ~rd_word[7];
                  tx_ff    <= {rd_word[6:0], 1'b0};
                  hi_ff    <= 1'b1;
                  ptr_ff   <= ptr_ff + 8'h01;
                  state_ff <= ST_RDATA;
               end else begin
                  oe_ff    <= ~rd_word[15];
                  tx_ff    <= {rd_word[14:8], 1'b0};
                  hi_ff    <= 1'b0;
                  state_ff <= ST_RDATA;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // word store; numbers past the store accept and drop writes
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < int'(WORD_COUNT); i++) begin
            words_ff[i] <= WORD_RESET;
         end
      end else if (wr_en && in_range(ptr_ff)) begin
         words_ff[ptr_ff[4:0]] <= wr_word;
      end
   end

   // ----------------------------------------------------------------
   // decoded configuration, registered
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cfg <= '0;
      end else begin
         cfg.supply_code   <= words_ff[NOMINAL_SUPPLY_WORD[4:0]][SUPPLY_LSB +: 8];
         cfg.rated_speed   <= words_ff[RATED_SPEED_AND_FLAGS_WORD[4:0]][SPEED_LSB +: 11];
         cfg.rated_current <= words_ff[CURRENT_SETTING_WORD[4:0]][CURR_LSB +: 11];
         // product fits 17 bits; dividing by 8 leaves 14
         cfg.launch_current <= 14'((17'(words_ff[CURRENT_SETTING_WORD[4:0]][CURR_LSB +: 11])
                                 * (17'(words_ff[CURRENT_SETTING_WORD[4:0]][LAUNCH_LSB +: 5]) + 17'h1))
                                 >> 3);
         cfg.probe_limit   <= words_ff[PROBE_THRESHOLD_WORD[4:0]][PROBE_LSB +: 6];
         cfg.nudge_tenths  <= 8'(words_ff[NUDGE_AND_DUTY_WORD[4:0]][NUDGE_LSB +: 3]) * NUDGE_STEP
                              + NUDGE_BASE;
         cfg.tuning_window <= words_ff[DRIVE_AND_STARTUP_WORD[4:0]][TUNE_BIT];
         cfg.auto_recover  <= words_ff[PROTECTION_AND_BUFFER_WORD[4:0]][RECOV_BIT];
      end
   end

   // speed command source: register field or measured pin duty
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         speed_cmd <= 9'h000;
      end else if (words_ff[SPEED_COMMAND_WORD[4:0]][SEL_BIT]) begin
         speed_cmd <= words_ff[SPEED_COMMAND_WORD[4:0]][DEMAND_LSB +: 9];
      end else begin
         speed_cmd <= duty_pin_cmd;
      end
   end

   assign sda_out = 1'b0;   // open drain: only ever pulls low
   assign sda_oe  = oe_ff;

   // ----------------------------------------------------------------
   // startup delay and overcurrent recovery
   // ----------------------------------------------------------------
   logic [26:0] delay_cnt_ff;
   logic [26:0] recov_cnt_ff;
   logic        start_d_ff;
   logic        restart;

   assign restart = start_req & ~start_d_ff;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         start_d_ff   <= 1'b0;
         delay_cnt_ff <= 27'h0;
         motor_run    <= 1'b0;
      end else begin
         start_d_ff <= start_req;
         if (!start_req || fault_active) begin
            delay_cnt_ff <= 27'h0;
            motor_run    <= 1'b0;
         end else if (!motor_run) begin
            // hold off for the delay when the flag is set
            if (!words_ff[OBSERVER_GAIN_I_WORD[4:0]][DELAY_BIT] ||
                delay_cnt_ff >= 27'(DELAY_CNT - 1)) begin
               motor_run <= 1'b1;
            end else begin
               delay_cnt_ff <= delay_cnt_ff + 27'h1;
            end
         end
      end
   end

   // a new event in the clearing cycle keeps the fault set
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         fault_active <= 1'b0;
         recov_cnt_ff <= 27'h0;
      end else if (overcurrent_event) begin
         fault_active <= 1'b1;
         recov_cnt_ff <= 27'h0;
      end else if (fault_active) begin
         if (!cfg.auto_recover) begin
            recov_cnt_ff <= 27'h0;
            if (restart) begin
               fault_active <= 1'b0;
            end
         end else if (recov_cnt_ff >= 27'(RECOVER_CNT - 1)) begin
            fault_active <= 1'b0;
            recov_cnt_ff <= 27'h0;
         end else begin
            recov_cnt_ff <= recov_cnt_ff + 27'h1;
         end
      end
   end
endmodule // motor_param_config_bank

// File: bench/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model #(
   parameter int unsigned HOLD = 6
)(
   // system clock
   input  wire logic clock,
   // device side of the open-drain data wire
   input  wire logic dev_oe,
   input  wire logic dev_out,
   // bus wires as seen by both ends
   output logic      scl,
   output logic      sda
);
   logic sda_drv = 1'b1;
   logic nak_acc = 1'b0;
   initial scl = 1'b1;
   // pull-up wins unless someone drives low, so a released line reads high
   assign sda = sda_drv & (dev_oe ? dev_out : 1'b1);
   // each phase lasts HOLD clocks, above the 4-clock minimum
   task automatic gap();
      repeat (HOLD) @(posedge clock);
   endtask
   // data moves only while the bus clock is low, sampled after the rise
   task automatic bit_io(input logic b, output logic s);
      scl <= 1'b0;
      gap();
      sda_drv <= b;
      gap();
      scl <= 1'b1;
      gap();
      s = sda;
   endtask
   task automatic frame_start();
      logic s;
      bit_io(1'b1, s);
      sda_drv <= 1'b0;
      gap();
   endtask
   task automatic frame_stop();
      logic s;
      bit_io(1'b0, s);
      sda_drv <= 1'b1;
      gap();
   endtask
   // eight bits msb first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] b, output logic [7:0] r, input logic ak);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(ak, s);
      nak_acc = nak_acc | s;
   endtask
   // word goes high byte first
   task automatic write_word(input logic [6:0] a, input logic [7:0] rn, input logic [15:0] v);
      logic [7:0] r;
      nak_acc = 1'b0;
      frame_start();
      byte_io({a, 1'b0}, r, 1'b1);
      byte_io(rn, r, 1'b1);
      byte_io(v[15:8], r, 1'b1);
      byte_io(v[7:0], r, 1'b1);
      frame_stop();
   endtask
   task automatic read_word(input logic [6:0] a, input logic [7:0] rn, output logic [15:0] v);
      logic [7:0] r;
      frame_start();
      byte_io({a, 1'b0}, r, 1'b1);
      byte_io(rn, r, 1'b1);
      frame_start();
      byte_io({a, 1'b1}, r, 1'b1);
      byte_io(8'hff, v[15:8], 1'b0);
      byte_io(8'hff, v[7:0], 1'b1);
      frame_stop();
   endtask
endmodule // serial_host_model

// File: bench/motor_param_config_bank_properties.sv
`timescale 1ns/1ps
module motor_param_config_bank_properties
   import motor_cfg_pkg::*;
#(
   parameter int unsigned DELAY_CNT   = DELAY_CYCLES,
   parameter int unsigned RECOVER_CNT = RECOVER_CYCLES
)(
   // clock and reset
   input wire logic       clock,
   input wire logic       reset_n,
   // serial bus
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   // motor side
   input wire logic       start_req,
   input wire logic       overcurrent_event,
   input wire logic [8:0] duty_pin_cmd,
   input wire logic [8:0] speed_cmd,
   input wire logic       motor_run,
   input wire logic       fault_active,
   input wire motor_cfg_t cfg
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // cycles since the last overcurrent event, saturating so it never wraps
   logic [31:0] since_evt_ff;
   always_ff @(posedge clock) begin
      if (!reset_n || overcurrent_event) begin
         since_evt_ff <= 32'h0;
      end else if (since_evt_ff != 32'hffffffff) begin
         since_evt_ff <= since_evt_ff + 32'h1;
      end
   end
   a_sda_pull_low:  assert property (sda_out == 1'b0) else $error("data wire driven high");
   a_ack_scl_low:   assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
   a_fault_sets:    assert property (overcurrent_event |=> fault_active) else $error("fault not latched");
   a_run_needs_start: assert property (!start_req |=> !motor_run) else $error("run without start");
   a_fault_stops_run: assert property (fault_active |=> !motor_run) else $error("run during fault");
   a_run_rise_cause: assert property ($rose(motor_run) |-> $past(start_req) && !$past(fault_active))
      else $error("run rose without cause");
   a_manual_clear:  assert property ($fell(fault_active) && !$past(cfg.auto_recover) |->
      $past(start_req) && !$past(start_req, 2)) else $error("fault cleared without restart");
   a_auto_clear_time: assert property ($fell(fault_active) && $past(cfg.auto_recover) |->
      since_evt_ff + 32'h1 >= RECOVER_CNT && since_evt_ff <= RECOVER_CNT + 1)
      else $error("auto clear at wrong time");
   a_nudge_form:    assert property ($past(reset_n) |-> cfg.nudge_tenths[4:0] == 5'h18)
      else $error("nudge demand off its grid");
   a_launch_bound:  assert property (cfg.launch_current <= {1'b0, cfg.rated_current, 2'b00})
      else $error("launch current above four times rated");
endmodule // motor_param_config_bank_properties
bind motor_param_config_bank motor_param_config_bank_properties #(.DELAY_CNT(DELAY_CNT), .RECOVER_CNT(RECOVER_CNT))
   u_props (.clock(clock), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .start_req(start_req), .overcurrent_event(overcurrent_event), .duty_pin_cmd(duty_pin_cmd),
   .speed_cmd(speed_cmd), .motor_run(motor_run), .fault_active(fault_active), .cfg(cfg));

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import motor_cfg_pkg::*;
   // ----------------------------------------------------------------
   // bench state
   // ----------------------------------------------------------------
   localparam int unsigned DLY = 20;
   localparam int unsigned REC = 50;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        start_req = 1'b0;
   logic        overcurrent_event = 1'b0;
   logic [8:0]  duty_pin_cmd = 9'h000;
   logic        scl, sda, sda_out, sda_oe, motor_run, fault_active;
   logic [8:0]  speed_cmd;
   motor_cfg_t  cfg;
   logic [15:0] words [24];
   logic [15:0] d;
   logic [7:0]  regs [13] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h14,
                              8'h15, 8'h16};
   int          err_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          n;
   // ----------------------------------------------------------------
   // design and host
   // ----------------------------------------------------------------
   motor_param_config_bank #(.DELAY_CNT(DLY), .RECOVER_CNT(REC)) u_motor_param_config_bank (.clock(clock),
      .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .start_req(start_req),
      .overcurrent_event(overcurrent_event), .duty_pin_cmd(duty_pin_cmd), .speed_cmd(speed_cmd),
      .motor_run(motor_run), .fault_active(fault_active), .cfg(cfg));
   serial_host_model u_serial_host_model (.clock(clock), .dev_oe(sda_oe), .dev_out(sda_out), .scl(scl), .sda(sda));
   // 50 ns period
   always #25 clock = ~clock;
   // hang guard, about twice the expected run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         wrap_up();
      end
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic put(input logic [7:0] rn, input logic [15:0] v);
      u_serial_host_model.write_word(BUS_ADDR_DEFAULT, rn, v);
      check(u_serial_host_model.nak_acc, 1'b0);
      if (rn < 8'h18) words[rn] = v;
   endtask
   task automatic get_chk(input logic [7:0] rn, input logic [15:0] exp);
      logic [15:0] r;
      u_serial_host_model.read_word(BUS_ADDR_DEFAULT, rn, r);
      check(r, exp);
   endtask
   // configuration the block should present for the current words
   function automatic motor_cfg_t exp_cfg();
      motor_cfg_t c;
      c.supply_code    = words[20][7:0];
      c.rated_speed    = words[8][10:0];
      c.rated_current  = words[10][10:0];
      c.launch_current = 14'((17'(words[10][10:0]) * (17'(words[10][15:11]) + 17'h1)) >> 3);
      c.probe_limit    = words[18][13:8];
      c.nudge_tenths   = {5'h00, words[21][7:5]} * 8'h20 + 8'h18;
      c.tuning_window  = words[11][15];
      c.auto_recover   = words[16][3];
      return c;
   endfunction
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(96369));
      foreach (words[i]) words[i] = WORD_RESET;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(negedge clock);
      check(cfg, exp_cfg());
      check(speed_cmd, duty_pin_cmd);
      // random words, then all ones as the boundary value
      for (int r = 0; r < 2; r++) begin
         foreach (regs[i]) put(regs[i], r ? 16'hffff : 16'($urandom));
         foreach (regs[i]) get_chk(regs[i], words[regs[i]]);
         @(negedge clock);
         check(cfg, exp_cfg());
      end
      // last word of the store, one past it, and a foreign bus address
      d = 16'($urandom);
      put(8'h17, d);
      get_chk(8'h17, d);
      put(8'h18, d);
      get_chk(8'h18, 16'h0000);
      u_serial_host_model.write_word(7'h15, NOMINAL_SUPPLY_WORD, ~words[20]);
      check(u_serial_host_model.nak_acc, 1'b1);
      get_chk(NOMINAL_SUPPLY_WORD, words[20]);
      // speed source: duty pin, then register field
      for (int k = 0; k < 2; k++) begin
         d = {6'h00, k[0], 9'($urandom)};
         put(SPEED_COMMAND_WORD, d);
         @(posedge clock);
         duty_pin_cmd <= 9'($urandom);
         repeat (3) @(negedge clock);
         check(speed_cmd, k ? d[8:0] : duty_pin_cmd);
      end
      // startup without and with the launch delay
      for (int f = 0; f < 2; f++) begin
         put(OBSERVER_GAIN_I_WORD, {1'b0, f[0], 14'($urandom)});
         @(posedge clock);
         start_req <= 1'b1;
         n = 0;
         do begin @(negedge clock); n++; end while (motor_run !== 1'b1 && n < 100);
         check(n, f ? DLY + 1 : 2);
         @(posedge clock);
         start_req <= 1'b0;
         repeat (3) @(negedge clock);
         check(motor_run, 1'b0);
      end
      // overcurrent: manual recovery, then timed recovery; event beats the restart edge
      for (int m = 0; m < 2; m++) begin
         put(PROTECTION_AND_BUFFER_WORD, {12'($urandom), m[0], 3'($urandom)});
         @(posedge clock);
         start_req <= 1'b1;
         overcurrent_event <= 1'b1;
         @(posedge clock);
         overcurrent_event <= 1'b0;
         n = 0;
         do begin @(negedge clock); n++; end while (fault_active !== 1'b0 && n < 200);
         check(n, m ? REC + 1 : 200);
         if (m == 0) begin
            @(posedge clock);
            start_req <= 1'b0;
            repeat (3) @(posedge clock);
            start_req <= 1'b1;
            repeat (2) @(negedge clock);
            check(fault_active, 1'b0);
         end
      end
      wrap_up();
   end
endmodule // testbench
